// >>> pkg/prc_map.svh
// constants for the processor reset control block
`ifndef PRC_MAP_SVH
`define PRC_MAP_SVH

// control pins, bit order {den_n, ale, wr_n, rd_n}
`define PRC_CTRL_W 4
`define PRC_CTRL_INACTIVE 4'hb
// three lower upper address pins
`define PRC_UPPER_W 3
// cycles the control pins are driven inactive before they float
`define PRC_DRIVE_CYCLES 4'h1
`define PRC_CNT_W 4
// pin level while reset holds the pins as inputs, and test mode level after power-on reset
`define PRC_PIN_IDLE 1'b1
`define PRC_TEST_MODE_RST 1'b0

`endif

// >>> pkg/prc_pkg.sv
// types of the processor reset control block
package prc_pkg;

  typedef enum logic [2:0] {
    PRC_RUN   = 3'b001,
    PRC_DRIVE = 3'b010,
    PRC_FLOAT = 3'b100
  } prc_state_t;

endpackage

// >>> rtl/prc_sync.sv
// two flip-flop synchronizer for the active-low reset request
`timescale 1ns/1ps
module prc_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // level in and synchronized level out
  input wire logic async_n,
  output logic sync_n
);

  logic meta_n;

  // resets to the asserted level so the core stays held until two clean edges
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_n <= 1'b0;
      sync_n <= 1'b0;
    end else begin
      meta_n <= async_n;
      sync_n <= meta_n;
    end
  end

endmodule

// >>> rtl/prc_reset_control.sv
// reset sequencing, bus abort, pin release and test strap capture
//
// Behaviour
// - reset request low resets at any time
// - reset request synchronized to clock before use
// - abort bus cycle, drive inactive, then float
// - reset stops activity, returns core to initial
// - lock and upper address become pulled-up inputs
// - top address low in reset selects test
`timescale 1ns/1ps
`include "prc_map.svh"
module prc_reset_control #(
  parameter int CTRL_W = `PRC_CTRL_W,
  parameter int UPPER_W = `PRC_UPPER_W,
  parameter logic [`PRC_CNT_W-1:0] DRIVE_CYCLES = `PRC_DRIVE_CYCLES
) (
  // clock and power-on reset of this logic
  input wire logic clk,
  input wire logic rst,
  // external reset request
  input wire logic reset_request_n,
  // core side bus values
  input wire logic core_bus_active,
  input wire logic [CTRL_W-1:0] core_ctrl,
  input wire logic core_lock,
  input wire logic core_top_address,
  input wire logic [UPPER_W-1:0] core_upper_address,
  // core control
  output logic core_reset,
  output logic bus_abort,
  output logic pin_isolation_test_mode,
  // control pins
  output logic [CTRL_W-1:0] ctrl_out,
  output logic ctrl_oe_n,
  // lock pin
  input wire logic lock_in,
  output logic lock_out,
  output logic lock_oe_n,
  // top address pin doubling as test strap
  input wire logic top_address_test_strap_in,
  output logic top_address_test_strap_out,
  output logic top_address_test_strap_oe_n,
  // upper address pins
  input wire logic [UPPER_W-1:0] upper_address_pins_in,
  output logic [UPPER_W-1:0] upper_address_pins_out,
  output logic upper_address_pins_oe_n,
  // weak pullups on lock and address pins
  output logic pin_pullup_en
);

  localparam logic [CTRL_W-1:0] CTRL_INACTIVE = CTRL_W'(`PRC_CTRL_INACTIVE);

  prc_pkg::prc_state_t state;
  prc_pkg::prc_state_t next_state;
  logic req_sync_n;
  logic [`PRC_CNT_W-1:0] drive_cnt;
  logic drive_done;
  logic release_edge;

  // lock_in and upper_address_pins_in are never looked at: the board only holds them high on the pullup during reset
  prc_sync u_sync (
    .clk(clk),
    .rst(rst),
    .async_n(reset_request_n),
    .sync_n(req_sync_n)
  );

  assign drive_done = (drive_cnt == DRIVE_CYCLES);
  assign release_edge = (state == prc_pkg::PRC_FLOAT) && req_sync_n;

  always_comb begin
    next_state = state;
    unique case (state)
      prc_pkg::PRC_RUN: begin
        if (!req_sync_n) begin
          next_state = prc_pkg::PRC_DRIVE;
        end
      end
      prc_pkg::PRC_DRIVE: begin
        if (drive_done) begin
          next_state = prc_pkg::PRC_FLOAT;
        end
      end
      prc_pkg::PRC_FLOAT: begin
        if (req_sync_n) begin
          next_state = prc_pkg::PRC_RUN;
        end
      end
      default: begin
        next_state = prc_pkg::PRC_FLOAT;
      end
    endcase
  end

  // power-on reset lands straight in the floating hold, nothing to abort yet
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= prc_pkg::PRC_FLOAT;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      drive_cnt <= '0;
    end else if (state == prc_pkg::PRC_DRIVE) begin
      drive_cnt <= drive_cnt + `PRC_CNT_W'(1);
    end else begin
      drive_cnt <= `PRC_CNT_W'(1);
    end
  end

  // core held in reset through both the drive and the float phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      core_reset <= 1'b1;
    end else begin
      core_reset <= (next_state != prc_pkg::PRC_RUN);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_abort <= 1'b0;
    end else begin
      bus_abort <= (state == prc_pkg::PRC_RUN) && !req_sync_n && core_bus_active;
    end
  end

  // control pins: core values, then inactive levels, then released
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_out <= CTRL_INACTIVE;
      ctrl_oe_n <= 1'b1;
    end else begin
      unique case (next_state)
        prc_pkg::PRC_RUN: begin
          ctrl_out <= core_ctrl;
          ctrl_oe_n <= 1'b0;
        end
        prc_pkg::PRC_DRIVE: begin
          ctrl_out <= CTRL_INACTIVE;
          ctrl_oe_n <= 1'b0;
        end
        default: begin
          ctrl_out <= CTRL_INACTIVE;
          ctrl_oe_n <= 1'b1;
        end
      endcase
    end
  end

  // lock and address pins turn to pulled-up inputs for the whole reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lock_out <= `PRC_PIN_IDLE;
      top_address_test_strap_out <= `PRC_PIN_IDLE;
      upper_address_pins_out <= {UPPER_W{`PRC_PIN_IDLE}};
      lock_oe_n <= 1'b1;
      top_address_test_strap_oe_n <= 1'b1;
      upper_address_pins_oe_n <= 1'b1;
      pin_pullup_en <= 1'b1;
    end else if (next_state == prc_pkg::PRC_RUN) begin
      lock_out <= core_lock;
      top_address_test_strap_out <= core_top_address;
      upper_address_pins_out <= core_upper_address;
      lock_oe_n <= 1'b0;
      top_address_test_strap_oe_n <= 1'b0;
      upper_address_pins_oe_n <= 1'b0;
      pin_pullup_en <= 1'b0;
    end else begin
      lock_out <= `PRC_PIN_IDLE;
      top_address_test_strap_out <= `PRC_PIN_IDLE;
      upper_address_pins_out <= {UPPER_W{`PRC_PIN_IDLE}};
      lock_oe_n <= 1'b1;
      top_address_test_strap_oe_n <= 1'b1;
      upper_address_pins_oe_n <= 1'b1;
      pin_pullup_en <= 1'b1;
    end
  end

  // strap sampled only on the release edge, a glitch mid-run cannot change the mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_isolation_test_mode <= `PRC_TEST_MODE_RST;
    end else if (release_edge) begin
      pin_isolation_test_mode <= !top_address_test_strap_in;
    end
  end

  property p_enter;
    @(posedge clk) disable iff (rst)
      (!reset_request_n)[*3] |=> core_reset;
  endproperty
  a_enter: assert property (p_enter) else $error("reset request did not reset core");

  property p_sync_delay;
    @(posedge clk) disable iff (rst)
      reset_request_n[*3] ##1 !reset_request_n |-> (!core_reset)[*2];
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("reset acted before sync");

  property p_inactive_before_float;
    @(posedge clk) disable iff (rst)
      $rose(ctrl_oe_n) |-> $past(ctrl_out) == CTRL_INACTIVE && !$past(ctrl_oe_n);
  endproperty
  a_inactive_before_float: assert property (p_inactive_before_float)
    else $error("control pins floated without inactive drive");

  property p_abort;
    @(posedge clk) disable iff (rst)
      state == prc_pkg::PRC_RUN && !req_sync_n && core_bus_active |=> bus_abort ##1 !bus_abort;
  endproperty
  a_abort: assert property (p_abort) else $error("bus cycle not aborted");

  // a synchronized request low must hold the core and quiet the control pins next cycle
  property p_core_held;
    @(posedge clk) disable iff (rst)
      !req_sync_n |=> core_reset && (ctrl_out == CTRL_INACTIVE);
  endproperty
  a_core_held: assert property (p_core_held) else $error("core left reset early");

  property p_pins_input;
    @(posedge clk) disable iff (rst)
      state == prc_pkg::PRC_FLOAT |-> lock_oe_n && upper_address_pins_oe_n
        && top_address_test_strap_oe_n && pin_pullup_en;
  endproperty
  a_pins_input: assert property (p_pins_input) else $error("pins driven during reset");

  property p_strap;
    @(posedge clk) disable iff (rst)
      $fell(core_reset) |-> pin_isolation_test_mode == !$past(top_address_test_strap_in);
  endproperty
  a_strap: assert property (p_strap) else $error("test strap not captured");

  property p_mode_hold;
    @(posedge clk) disable iff (rst)
      !core_reset && !$past(core_reset) |-> $stable(pin_isolation_test_mode);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("test mode changed while running");

endmodule

// >>> sim/prc_board.sv
// board model: reset source and strap circuit beside the device pins
`timescale 1ns/1ps
module prc_board (
  // commands from the bench
  input wire logic req_cmd,
  input wire logic strap_low,
  // device pin drive
  input wire logic pull_en,
  input wire logic lock_out,
  input wire logic lock_oe_n,
  input wire logic top_out,
  input wire logic top_oe_n,
  input wire logic [2:0] up_out,
  input wire logic up_oe_n,
  // pin levels back to the device
  output logic reset_request_n,
  output logic lock_in,
  output logic top_in,
  output logic [2:0] up_in
);
  // held low from power-on until the bench lets go
  assign reset_request_n = req_cmd;
  // released pins rest on the weak pullup, or show a wrong level without it
  assign lock_in = !lock_oe_n ? lock_out : (pull_en ? 1'b1 : ~lock_out);
  assign up_in = !up_oe_n ? up_out : (pull_en ? 3'h7 : ~up_out);
  // only the strap may be pulled low
  assign top_in = !top_oe_n ? top_out : (pull_en ? !strap_low : ~top_out);
endmodule

// >>> sim/prc_reset_control_tb.sv
// self-checking bench for the processor reset control
`timescale 1ns/1ps
module prc_reset_control_tb;
  logic clk, rst, req_cmd, strap_low, act, lock, top, prev, exp_mode;
  logic core_reset, bus_abort, mode, ctrl_oe_n, lock_out, lock_oe_n, top_out, top_oe_n;
  logic up_oe_n, pu_en, req_n, lock_in, top_in;
  logic [3:0] ctrl, ctrl_out;
  logic [2:0] up, up_out, up_in;
  logic [7:0] lfsr;
  logic [15:0] note;
  logic [15:0] q[$];
  int n_mismatch, checked;

  prc_reset_control DUT (.clk(clk), .rst(rst), .reset_request_n(req_n),
    .core_bus_active(act), .core_ctrl(ctrl), .core_lock(lock), .core_top_address(top),
    .core_upper_address(up), .core_reset(core_reset), .bus_abort(bus_abort),
    .pin_isolation_test_mode(mode), .ctrl_out(ctrl_out), .ctrl_oe_n(ctrl_oe_n),
    .lock_in(lock_in), .lock_out(lock_out), .lock_oe_n(lock_oe_n),
    .top_address_test_strap_in(top_in), .top_address_test_strap_out(top_out),
    .top_address_test_strap_oe_n(top_oe_n), .upper_address_pins_in(up_in),
    .upper_address_pins_out(up_out), .upper_address_pins_oe_n(up_oe_n),
    .pin_pullup_en(pu_en));

  prc_board board (.req_cmd(req_cmd), .strap_low(strap_low), .pull_en(pu_en),
    .lock_out(lock_out), .lock_oe_n(lock_oe_n), .top_out(top_out), .top_oe_n(top_oe_n),
    .up_out(up_out), .up_oe_n(up_oe_n), .reset_request_n(req_n), .lock_in(lock_in),
    .top_in(top_in), .up_in(up_in));

  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  task check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task test_done;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // each edge of core_reset takes the oldest note
  always @(posedge clk) begin
    #1;
    if (!rst && core_reset !== prev) begin
      note = (q.size() > 0) ? q.pop_front() : 16'hffff;
      check("reset event", note, 16'({core_reset, bus_abort, ctrl_oe_n, ctrl_out,
        pu_en, mode}));
    end
    prev = core_reset;
  end

  task wait_reset(input logic lvl);
    int n;
    n = 0;
    while (core_reset !== lvl && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("reset latency", 16'h3, 16'(n));
    if (n == 8) test_done;
  endtask

  task release_req(input logic s);
    @(negedge clk);
    req_cmd = 1;
    strap_low = s;
    q.push_back(16'({1'b0, 1'b0, 1'b0, ctrl, 1'b0, s}));
    wait_reset(0);
    exp_mode = s;
    @(negedge clk);
    strap_low = !s;
  endtask

  task warm(input logic a, input logic s);
    @(negedge clk);
    req_cmd = 0;
    act = a;
    q.push_back(16'({1'b1, a, 1'b0, 4'hb, 1'b1, exp_mode}));
    wait_reset(1);
    @(negedge clk);
    // first reset cycle: control pins still driven inactive, abort pulse up if bus was busy
    check("drive", 16'({1'b0, 3'h7, a, 1'b1}),
      16'({ctrl_oe_n, lock_oe_n, top_oe_n, up_oe_n, bus_abort, pu_en}));
    @(negedge clk);
    // inactive drive lasts one cycle, then everything floats
    check("float", 16'h3d,
      16'({ctrl_oe_n, lock_oe_n, top_oe_n, up_oe_n, bus_abort, pu_en}));
    repeat (2) @(negedge clk);
    release_req(s);
  endtask

  task run;
    for (int i = 0; i < 12; i++) begin
      @(negedge clk);
      check("run pins", 16'({ctrl, lock, top, up, 4'h0, 1'b0, exp_mode}),
        16'({ctrl_out, lock_out, top_out, up_out, ctrl_oe_n, lock_oe_n, top_oe_n, up_oe_n,
         pu_en, mode}));
      lfsr = nxt(lfsr);
      {top, lock, ctrl} = lfsr[5:0];
      up = lfsr[7:5];
      act = lfsr[0];
    end
  endtask

  initial begin
    rst = 1;
    req_cmd = 0;
    strap_low = 0;
    act = 0;
    ctrl = 4'h0;
    lock = 0;
    top = 0;
    up = 3'h0;
    lfsr = 8'h37;
    exp_mode = 0;
    prev = 1;
    n_mismatch = 0;
    checked = 0;
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst = 0;
    // request stays low while the clock already runs
    repeat (4) @(negedge clk);
    check("held", 16'h1, {15'h0, core_reset});
    release_req(1);
    run();
    warm(1, 0);
    run();
    warm(0, 1);
    run();
    warm(1, 1);
    run();
    test_done;
  end
endmodule
